// [rtl/gpio_port_pkg.sv]
// Purpose: Constants shared by the seven-bit port design
// Assumes: 32-bit register bus, one word per register
// Notes: Offsets are byte addresses from the port base
package gpio_port_pkg;
  localparam int PIN_COUNT = 7;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam logic [7:0] OFF_PORT_DATA = 8'h00;
  localparam logic [7:0] OFF_PORT_OUTPUT_ENABLE = 8'h04;
  localparam logic [7:0] OFF_PORT_FUNCTION_SELECT_A = 8'h0C;
  localparam logic [7:0] OFF_PORT_FUNCTION_SELECT_B = 8'h10;
  localparam logic [7:0] OFF_PORT_PULLUP_ENABLE = 8'h2C;
  localparam logic [7:0] OFF_PORT_INPUT_ENABLE = 8'h38;
  localparam logic [7:0] OFF_PORT_MODE_CONTROL = 8'h40;
  localparam int FIELD_RESERVED_BIT = 7;
  localparam int FIELD_STOP_MODE_BIT = 0;
  localparam logic [7:0] RESET_REG8 = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    FUNC_PORT = 2'b00,
    FUNC_ALT_A = 2'b01,
    FUNC_ALT_B = 2'b10
  } pin_function_t;
endpackage

// [rtl/pin_input_sync.sv]
// Purpose: Bring external pin levels into the mclk domain
// Assumes: Pins change slowly compared to mclk
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps
module pin_input_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinLevel
);
  logic [WIDTH-1:0] stage1_q, stage2_q, stage3_q, level_q;
  logic [WIDTH-1:0] level_d;

  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_q[i] == stage3_q[i]) begin
        level_d[i] = stage3_q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q <= '0;
    end else begin
      stage1_q <= pinAsync;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end

  assign pinLevel = level_q;
endmodule // pin_input_sync

// [rtl/axil_reg_slave.sv]
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Master holds valid and payload until taken
// Notes: Write address and data may come in either order
`timescale 1ns/1ps
module axil_reg_slave
  import gpio_port_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrStrobe,
  output logic [ADDR_WIDTH-1:0] wrAddr,
  output logic [DATA_WIDTH-1:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrHit,
  output logic [ADDR_WIDTH-1:0] rdAddr,
  input wire logic [DATA_WIDTH-1:0] rdData,
  input wire logic rdHit
);
  logic awHave_q, awHave_d, wHave_q, wHave_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [ADDR_WIDTH-1:0] awaddr_q, awaddr_d;
  logic [DATA_WIDTH-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [ADDR_WIDTH-1:0] araddr_q, araddr_d;
  logic [DATA_WIDTH-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic arPend_q, arPend_d;

  // Commit in the same cycle both halves are held
  assign wrStrobe = awHave_q && wHave_q && !bvalid_q;
  assign wrAddr = awaddr_q;
  assign wrData = wdata_q;
  assign wrStrb = wstrb_q;
  assign rdAddr = araddr_q;

  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !awHave_q) begin
      awHave_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_q) begin
      wHave_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wrStrobe) begin
      bvalid_d = 1'b1;
      bresp_d = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
      awHave_d = 1'b0;
      wHave_d = 1'b0;
    end
  end

  always_comb begin
    // Ready stays up while idle instead of toggling
    arready_d = !arPend_q && !rvalid_q;
    arPend_d = arPend_q;
    araddr_d = araddr_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arready_q && s_axi_arvalid) begin
      arready_d = 1'b0;
      arPend_d = 1'b1;
      araddr_d = s_axi_araddr;
    end
    if (arPend_q) begin
      arPend_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = rdHit ? rdData : '0;
      rresp_d = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      arPend_q <= 1'b0;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      arPend_q <= arPend_d;
      araddr_q <= araddr_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule // axil_reg_slave

// [rtl/seven_bit_gpio_port.sv]
// Purpose: Seven-pin general-purpose port with alternate function routing
// Assumes: Software keeps select bits exclusive and reserved offsets untouched
// Notes: Registers on AXI4-Lite; pins are in, out and enable signals
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Seven pins, each input or output
// - Reset leaves pins plain, all buffers off
// - Two select bits per pin choose function
// - Input-enabled pins reach interrupts except stop
// - Data, output, select registers at fixed offsets
// - Pull-up, input and mode control registers; rest reserved
// - Data bits 6-0, bit 7 reserved
// - Output control bits enable drivers, reset zero
// - Pull-up bits enable pull-ups, bit 7 reserved
module seven_bit_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOutEnable,
  output logic [PINS-1:0] pinPullupEnable,
  output logic [PINS-1:0] pinInputBufferEnable,
  input wire logic [PINS-1:0] altOut,
  output logic [PINS-1:0] analogSelect,
  output logic [PINS-1:0] extIntIn,
  output logic [PINS-1:0] timerIn
);
  // Stored bytes: bit 7 is the reserved read/write bit where kept
  logic [7:0] portData_q, portData_d;
  logic [7:0] outputEnable_q, outputEnable_d;
  logic [7:0] funcSelA_q, funcSelA_d;
  logic [7:0] funcSelB_q, funcSelB_d;
  logic [7:0] pullupEnable_q, pullupEnable_d;
  logic [7:0] inputEnable_q, inputEnable_d;
  logic stopMode_q, stopMode_d;
  logic [PINS-1:0] pinOut_q, pinOut_d, pinOe_q, pinOe_d;
  logic [PINS-1:0] pullup_q, pullup_d, inBuf_q, inBuf_d;
  logic [PINS-1:0] analog_q, analog_d, extInt_q, extInt_d, timer_q, timer_d;
  logic [PINS-1:0] pinLevel;
  logic wrStrobe, wrHit, rdHit;
  logic [ADDR_WIDTH-1:0] wrAddr, rdAddr;
  logic [DATA_WIDTH-1:0] wrData, rdData;
  logic [3:0] wrStrb;

  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
    case (addr)
      OFF_PORT_DATA, OFF_PORT_OUTPUT_ENABLE, OFF_PORT_FUNCTION_SELECT_A,
      OFF_PORT_FUNCTION_SELECT_B, OFF_PORT_PULLUP_ENABLE,
      OFF_PORT_INPUT_ENABLE, OFF_PORT_MODE_CONTROL: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic pin_function_t pinFunction(input logic a, input logic b);
    pinFunction = pin_function_t'({b, a});
  endfunction

  axil_reg_slave u_bus (
    .mclk(mclk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  pin_input_sync #(.WIDTH(PINS)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinAsync(pinIn),
    .pinLevel(pinLevel)
  );

  // Reserved offsets answer with an error and store nothing
  assign wrHit = isMapped(wrAddr);
  assign rdHit = isMapped(rdAddr);

  always_comb begin
    portData_d = portData_q;
    outputEnable_d = outputEnable_q;
    funcSelA_d = funcSelA_q;
    funcSelB_d = funcSelB_q;
    pullupEnable_d = pullupEnable_q;
    inputEnable_d = inputEnable_q;
    stopMode_d = stopMode_q;
    // Only byte lane 0 holds state; upper lanes are read-as-zero
    if (wrStrobe && wrStrb[0]) begin
      case (wrAddr)
        OFF_PORT_DATA: portData_d = wrData[7:0];
        OFF_PORT_OUTPUT_ENABLE: outputEnable_d = wrData[7:0];
        OFF_PORT_FUNCTION_SELECT_A: funcSelA_d = wrData[7:0];
        OFF_PORT_FUNCTION_SELECT_B: funcSelB_d = wrData[7:0];
        OFF_PORT_PULLUP_ENABLE: pullupEnable_d = wrData[7:0];
        OFF_PORT_INPUT_ENABLE: inputEnable_d = wrData[7:0];
        OFF_PORT_MODE_CONTROL: stopMode_d = wrData[FIELD_STOP_MODE_BIT];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdData = '0;
    case (rdAddr)
      OFF_PORT_DATA: begin
        // Input-enabled pins read the pin; others read stored data
        rdData[7:0] = portData_q;
        for (int i = 0; i < PINS; i++) begin
          if (inputEnable_q[i]) begin
            rdData[i] = pinLevel[i];
          end
        end
      end
      OFF_PORT_OUTPUT_ENABLE: rdData[7:0] = outputEnable_q;
      OFF_PORT_FUNCTION_SELECT_A: rdData[7:0] = funcSelA_q;
      OFF_PORT_FUNCTION_SELECT_B: rdData[7:0] = funcSelB_q;
      OFF_PORT_PULLUP_ENABLE: rdData[7:0] = pullupEnable_q;
      OFF_PORT_INPUT_ENABLE: rdData[7:0] = inputEnable_q;
      OFF_PORT_MODE_CONTROL: rdData[FIELD_STOP_MODE_BIT] = stopMode_q;
      default: rdData = '0;
    endcase
  end

  // Pin side, registered so every output leaves a flip-flop
  always_comb begin
    pinOut_d = '0;
    pinOe_d = '0;
    analog_d = '0;
    timer_d = '0;
    extInt_d = '0;
    pullup_d = pullupEnable_q[PINS-1:0];
    inBuf_d = inputEnable_q[PINS-1:0];
    for (int i = 0; i < PINS; i++) begin
      unique case (pinFunction(funcSelA_q[i], funcSelB_q[i]))
        FUNC_PORT: begin
          pinOut_d[i] = portData_q[i];
          pinOe_d[i] = outputEnable_q[i];
        end
        FUNC_ALT_A: begin
          pinOut_d[i] = altOut[i];
          pinOe_d[i] = outputEnable_q[i];
          analog_d[i] = 1'b1;
        end
        FUNC_ALT_B: begin
          pinOut_d[i] = altOut[i];
          pinOe_d[i] = outputEnable_q[i];
          timer_d[i] = inputEnable_q[i] & pinLevel[i];
        end
        default: begin
          // Both set is forbidden to software; keep the pin quiet
          pinOut_d[i] = 1'b0;
          pinOe_d[i] = 1'b0;
        end
      endcase
      // Interrupt path ignores function select, gated by input enable and stop mode
      extInt_d[i] = inputEnable_q[i] & !stopMode_q & pinLevel[i];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      portData_q <= RESET_REG8;
      outputEnable_q <= RESET_REG8;
      funcSelA_q <= RESET_REG8;
      funcSelB_q <= RESET_REG8;
      pullupEnable_q <= RESET_REG8;
      inputEnable_q <= RESET_REG8;
      stopMode_q <= 1'b0;
      pinOut_q <= '0;
      pinOe_q <= '0;
      pullup_q <= '0;
      inBuf_q <= '0;
      analog_q <= '0;
      extInt_q <= '0;
      timer_q <= '0;
    end else begin
      portData_q <= portData_d;
      outputEnable_q <= outputEnable_d;
      funcSelA_q <= funcSelA_d;
      funcSelB_q <= funcSelB_d;
      pullupEnable_q <= pullupEnable_d;
      inputEnable_q <= inputEnable_d;
      stopMode_q <= stopMode_d;
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
      pullup_q <= pullup_d;
      inBuf_q <= inBuf_d;
      analog_q <= analog_d;
      extInt_q <= extInt_d;
      timer_q <= timer_d;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOutEnable = pinOe_q;
  assign pinPullupEnable = pullup_q;
  assign pinInputBufferEnable = inBuf_q;
  assign analogSelect = analog_q;
  assign extIntIn = extInt_q;
  assign timerIn = timer_q;

  property p_oe_follows_reg;
    @(posedge mclk) disable iff (!reset_n)
      (funcSelA_q == 8'h00 && funcSelB_q == 8'h00)
        |=> pinOutEnable == $past(outputEnable_q[PINS-1:0]);
  endproperty
  a_oe_follows_reg: assert property (p_oe_follows_reg)
    else $error("Output enable does not follow control register");

  property p_drive_data;
    @(posedge mclk) disable iff (!reset_n)
      (funcSelA_q[0] == 1'b0 && funcSelB_q[0] == 1'b0 && outputEnable_q[0])
        |=> pinOut[0] == $past(portData_q[0]);
  endproperty
  a_drive_data: assert property (p_drive_data)
    else $error("Pin 0 does not drive stored data");

  property p_int_stop;
    @(posedge mclk) disable iff (!reset_n)
      stopMode_q |=> extIntIn == '0;
  endproperty
  a_int_stop: assert property (p_int_stop)
    else $error("Interrupt input passed in stop mode");

  property p_int_pass;
    @(posedge mclk) disable iff (!reset_n)
      (!stopMode_q && inputEnable_q[1] && pinLevel[1]) |=> extIntIn[1];
  endproperty
  a_int_pass: assert property (p_int_pass)
    else $error("Input-enabled pin not passed to interrupt logic");

  property p_reserved_err;
    @(posedge mclk) disable iff (!reset_n)
      (wrStrobe && !isMapped(wrAddr)) |=> s_axi_bresp == RESP_SLVERR;
  endproperty
  a_reserved_err: assert property (p_reserved_err)
    else $error("Reserved offset write not answered with error");

  property p_upper_zero;
    @(posedge mclk) disable iff (!reset_n)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Upper data bits not zero");

  property p_pullup_out;
    @(posedge mclk) disable iff (!reset_n)
      ##1 pinPullupEnable == $past(pullupEnable_q[PINS-1:0]);
  endproperty
  a_pullup_out: assert property (p_pullup_out)
    else $error("Pull-up output does not follow register");

  property p_func_write;
    @(posedge mclk) disable iff (!reset_n)
      (wrStrobe && wrStrb[0] && wrAddr == OFF_PORT_FUNCTION_SELECT_A)
        |=> funcSelA_q == $past(wrData[7:0]);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("Function select write not stored");

  property p_analog_route;
    @(posedge mclk) disable iff (!reset_n)
      ##1 analogSelect == $past(funcSelA_q[PINS-1:0] & ~funcSelB_q[PINS-1:0]);
  endproperty
  a_analog_route: assert property (p_analog_route)
    else $error("Analog select does not follow select A");

  property p_timer_route;
    @(posedge mclk) disable iff (!reset_n)
      ##1 timerIn == $past(funcSelB_q[PINS-1:0] & ~funcSelA_q[PINS-1:0]
        & inputEnable_q[PINS-1:0] & pinLevel);
  endproperty
  a_timer_route: assert property (p_timer_route)
    else $error("Timer input does not follow select B");

  property p_inbuf_out;
    @(posedge mclk) disable iff (!reset_n)
      ##1 pinInputBufferEnable == $past(inputEnable_q[PINS-1:0]);
  endproperty
  a_inbuf_out: assert property (p_inbuf_out)
    else $error("Input buffer enable does not follow register");

  property p_mapped_ok;
    @(posedge mclk) disable iff (!reset_n)
      (wrStrobe && isMapped(wrAddr)) |=> s_axi_bresp == RESP_OKAY;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("Mapped offset write not answered with okay");

  property p_data_store;
    @(posedge mclk) disable iff (!reset_n)
      (wrStrobe && wrStrb[0] && wrAddr == OFF_PORT_DATA)
        |=> portData_q == $past(wrData[7:0]);
  endproperty
  a_data_store: assert property (p_data_store)
    else $error("Data register write not stored");

  // A reserved write must not disturb the data, output enable, select or pull-up bytes
  property p_reserved_nostore;
    @(posedge mclk) disable iff (!reset_n)
      (wrStrobe && !isMapped(wrAddr))
        |=> $stable({portData_q, outputEnable_q, funcSelA_q, funcSelB_q, pullupEnable_q});
  endproperty
  a_reserved_nostore: assert property (p_reserved_nostore)
    else $error("Reserved offset write changed a register");
endmodule // seven_bit_gpio_port

// [testbench/pin_world_model.sv]
// Purpose: Pin-side model of the seven-bit port
// Assumes: Outside drivers touch only pins the port leaves undriven
// Notes: Floating pins toggle so a stale level never passes for a match
`timescale 1ns/1ps
module pin_world_model (
  input wire logic mclk,
  input wire logic [6:0] pinOut,
  input wire logic [6:0] pinOutEnable,
  input wire logic [6:0] pinPullupEnable,
  input wire logic [6:0] extDrive,
  input wire logic [6:0] extLevel,
  output logic [6:0] pinIn
);
  logic [6:0] floatLevel = 7'h55;
  always @(posedge mclk) floatLevel <= ~floatLevel;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pinOutEnable[i]) pinIn[i] = pinOut[i];
      else if (extDrive[i]) pinIn[i] = extLevel[i];
      else if (pinPullupEnable[i]) pinIn[i] = 1'h1;
      else pinIn[i] = floatLevel[i];
    end
  end
endmodule // pin_world_model

// [testbench/seven_bit_gpio_port_test.sv]
// Purpose: Self-checking bench for the seven-bit port
// Assumes: One AXI4-Lite transfer at a time, pins modelled outside
// Notes: Handshakes are looked at before the edge that completes them
`timescale 1ns/1ps
module seven_bit_gpio_port_test;
  import gpio_port_pkg::*;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, w;
  logic [6:0] pinIn, pinOut, pinOutEnable, pinPullupEnable, pinInputBufferEnable;
  logic [6:0] analogSelect, extIntIn, timerIn;
  logic [6:0] altOut = 7'h00;
  logic [6:0] extLevel = 7'h00;
  logic [6:0] extDrive = 7'h7F;
  logic [6:0] oe, pu, ie, selA, selB, drv, lvl;
  logic [7:0] dat;
  logic [7:0] offs [6] = '{OFF_PORT_DATA, OFF_PORT_OUTPUT_ENABLE, OFF_PORT_FUNCTION_SELECT_A,
    OFF_PORT_FUNCTION_SELECT_B, OFF_PORT_PULLUP_ENABLE, OFF_PORT_INPUT_ENABLE};
  logic [7:0] rsv [9] = '{8'h08, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34};
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 72;

  seven_bit_gpio_port #(.PINS(7)) DUT (.mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pinIn(pinIn), .pinOut(pinOut),
    .pinOutEnable(pinOutEnable), .pinPullupEnable(pinPullupEnable),
    .pinInputBufferEnable(pinInputBufferEnable), .altOut(altOut),
    .analogSelect(analogSelect), .extIntIn(extIntIn), .timerIn(timerIn));

  pin_world_model world (.mclk(mclk), .pinOut(pinOut), .pinOutEnable(pinOutEnable),
    .pinPullupEnable(pinPullupEnable), .extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // About 110 transfers of under 10 cycles each; ceiling leaves wide margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Counts: checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpPins(input logic [6:0] got, input logic [6:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is registered, so its level before the edge is what the edge samples
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic tA, tW, tB;
    tB = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tB) begin
      @(negedge mclk);
      tA = s_axi_awvalid && s_axi_awready;
      tW = s_axi_wvalid && s_axi_wready;
      tB = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (tA) s_axi_awvalid <= 1'h0;
      if (tW) s_axi_wvalid <= 1'h0;
      if (tB) s_axi_bready <= 1'h0;
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tA, tR;
    tR = 1'h0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tR) begin
      @(negedge mclk);
      tA = s_axi_arvalid && s_axi_arready;
      tR = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (tA) s_axi_arvalid <= 1'h0;
      if (tR) s_axi_rready <= 1'h0;
    end
  endtask

  function automatic logic [31:0] expReg(input logic [31:0] d);
    return {24'h0, d[7:0]};
  endfunction

  function automatic logic [31:0] expData(input logic [7:0] s, input logic [6:0] e,
      input logic [6:0] l);
    return {24'h0, s[7], (s[6:0] & ~e) | (l & e)};
  endfunction

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmpPins(pinOutEnable | pinPullupEnable | pinInputBufferEnable, 7'h00);
    for (int i = 0; i < 6; i++) begin
      axiRead(offs[i], rd, resp);
      cmpWord(rd, 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      // Select B kept clear wherever select A was just set
      if (offs[i] == OFF_PORT_FUNCTION_SELECT_B) w = ~rd;
      if (offs[i] == OFF_PORT_FUNCTION_SELECT_A) selA = w[6:0];
      // Analog pins keep input and pull-up off
      if (offs[i] > OFF_PORT_FUNCTION_SELECT_B) w = w & ~{25'h0, selA};
      axiWrite(offs[i], w, resp);
      cmpResp(resp, RESP_OKAY);
      axiRead(offs[i], rd, resp);
      cmpWord(rd, expReg(w));
      cmpResp(resp, RESP_OKAY);
    end
    $display("test register map done");
    for (int i = 0; i < 9; i++) begin
      axiWrite(rsv[i], 32'hFFFFFFFF, resp);
      cmpResp(resp, RESP_SLVERR);
      axiRead(rsv[i], rd, resp);
      cmpWord(rd, 32'h0);
      cmpResp(resp, RESP_SLVERR);
    end
    $display("test reserved offsets done");
    for (int k = 0; k < 10; k++) begin
      w = $random(seed);
      {dat, oe, pu, ie} = w[28:0];
      if (k == 0) oe = 7'h7F;
      w = $random(seed);
      selA = w[6:0] & ~ie & ~pu;
      selB = w[13:7] & ~selA;
      altOut <= w[20:14];
      extLevel <= w[27:21];
      extDrive <= ~pu | w[6:0];
      axiWrite(OFF_PORT_FUNCTION_SELECT_A, {25'h0, selA}, resp);
      axiWrite(OFF_PORT_FUNCTION_SELECT_B, {25'h0, selB}, resp);
      axiWrite(OFF_PORT_PULLUP_ENABLE, {25'h0, pu}, resp);
      axiWrite(OFF_PORT_INPUT_ENABLE, {25'h0, ie}, resp);
      axiWrite(OFF_PORT_OUTPUT_ENABLE, {25'h0, oe}, resp);
      axiWrite(OFF_PORT_DATA, {24'h0, dat}, resp);
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      drv = (dat[6:0] & ~(selA | selB)) | (altOut & (selA | selB));
      // Undriven pins sit on their pull-up
      lvl = (oe & drv) | (~oe & ((extDrive & extLevel) | ~extDrive));
      cmpPins(pinOutEnable, oe);
      cmpPins(pinOut & oe, drv & oe);
      cmpPins(pinPullupEnable, pu);
      cmpPins(pinInputBufferEnable, ie);
      cmpPins(analogSelect, selA);
      cmpPins(timerIn, lvl & ie & selB);
      cmpPins(extIntIn, lvl & ie);
      axiRead(OFF_PORT_DATA, rd, resp);
      cmpWord(rd, expData(dat, ie, lvl));
    end
    $display("test pin paths done");
    axiWrite(OFF_PORT_MODE_CONTROL, 32'h1, resp);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    cmpPins(extIntIn, 7'h00);
    axiWrite(OFF_PORT_MODE_CONTROL, 32'h0, resp);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    cmpPins(extIntIn, lvl & ie);
    $display("test stop mode done");
    // Upper byte lanes alone must leave the register as it was
    s_axi_wstrb <= 4'hE;
    axiWrite(OFF_PORT_PULLUP_ENABLE, 32'hFFFFFFFF, resp);
    s_axi_wstrb <= 4'hF;
    axiRead(OFF_PORT_PULLUP_ENABLE, rd, resp);
    cmpWord(rd, {25'h0, pu});
    axiWrite(OFF_PORT_INPUT_ENABLE, 32'h0, resp);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    cmpPins(extIntIn, 7'h00);
    $display("test lanes and interrupt masking done");
    summarize();
  end
endmodule // seven_bit_gpio_port_test
